// ==== design/rpc_cfg.svh ====
`ifndef RPC_CFG_SVH
`define RPC_CFG_SVH

// Register addresses on the parameter port
`define RPC_ADDR_BAUD 16'h2600
`define RPC_ADDR_RESTART 16'h2f00
`define RPC_ADDR_CASCADE 16'h86b0
`define RPC_ADDR_PROTO 16'h86c0
`define RPC_ADDR_STORE 16'h2910
`define RPC_ADDR_STATION 16'h1000
`define RPC_ADDR_FORMAT 16'h1010

// Baud divisor codes
`define RPC_DIV_9600 16'h0438
`define RPC_DIV_19200 16'h021c
`define RPC_DIV_38400 16'h010e
`define RPC_DIV_115200 16'h005a

// Command codes
`define RPC_CMD_BOOT 16'h55aa
`define RPC_CMD_RESTART 16'haa55
`define RPC_CMD_STORE 16'h0001

// Protocol field positions
`define RPC_PROTO_SEL_BIT 0
`define RPC_PROTO_DEFER_BIT 1

// Reset values
`define RPC_STATION_RST 16'h0001
`define RPC_CASCADE_RST 8'h00
`define RPC_PROTO_RST_A 8'h00
`define RPC_PROTO_RST_B 8'h01

// Fixed 8N1 framing and its read-back word: stop [1:0], parity [3:2], data [7:4]
`define RPC_DATA_BITS 4'h8
`define RPC_STOP_BITS 2'h1
`define RPC_PARITY_EN 1'b0
`define RPC_FORMAT_WORD 16'h0081

// Bit reference in kHz generated from the system clock in kHz
`define RPC_REF_KHZ 18'h0_2880
`define RPC_MCLK_KHZ 18'h3_0d40

`endif

// ==== design/rpc_pkg.sv ====
`default_nettype none

package rpc_pkg;
  typedef enum logic {
    RPC_PROTO_MODBUS = 1'b0,
    RPC_PROTO_HOST = 1'b1
  } rpc_proto_type;

  typedef enum logic {
    RPC_VARIANT_A = 1'b0,
    RPC_VARIANT_B = 1'b1
  } rpc_variant_type;
endpackage

`default_nettype wire

// ==== design/rpc_port_config.sv ====
// How it works
// - Divisor codes 1080/540/270/90 select four baud rates
// - Station and baud apply only after restart
// - Protocol bit0 picks Modbus or host protocol
// - Protocol bit1 chooses immediate or deferred apply
// - Framing fixed at eight data, one stop
// - Variant A defaults to 38400 baud Modbus
// - Variant B defaults to 115200 host protocol
// - Cascade register picks one-to-one or cascade link
// - Writing 1 to protocol switches at once
// - Writing 3 to protocol defers until restart
// - 55AA starts bootloader, AA55 restarts drive
`timescale 1ns/1ps
`default_nettype none
`include "rpc_cfg.svh"

module rpc_port_config
  import rpc_pkg::*;
#(
  parameter rpc_variant_type VARIANT = RPC_VARIANT_A
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Parameter access port
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic reg_ack,
  output logic reg_err,
  output logic [15:0] reg_rdata,
  // Active port configuration
  output logic [15:0] baud_div,
  output logic [15:0] station_id,
  output logic proto_host,
  output logic cascade_mode,
  output logic [3:0] data_bits,
  output logic [1:0] stop_bits,
  output logic parity_en,
  // Bit timing and commands
  output logic bit_tick,
  output logic boot_req,
  output logic restart_req
);

  localparam logic [15:0] BAUD_RST =
    (VARIANT == RPC_VARIANT_B) ? `RPC_DIV_115200 : `RPC_DIV_38400;
  localparam logic [7:0] PROTO_RST =
    (VARIANT == RPC_VARIANT_B) ? `RPC_PROTO_RST_B : `RPC_PROTO_RST_A;

  // Pending (written), saved and active copies
  logic [15:0] baud_set_r, baud_set_nxt, baud_sav_r, baud_sav_nxt;
  logic [15:0] stn_set_r, stn_set_nxt, stn_sav_r, stn_sav_nxt;
  logic [1:0] proto_set_r, proto_set_nxt, proto_sav_r, proto_sav_nxt;
  logic [15:0] baud_r, baud_nxt, stn_r, stn_nxt;
  logic proto_r, proto_nxt, casc_r, casc_nxt;
  logic ack_r, ack_nxt, err_r, err_nxt, boot_r, boot_nxt, rst_r, rst_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [17:0] acc_r, acc_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;
  logic wr, rd, baud_ok;

  assign wr = reg_req && reg_we;
  assign rd = reg_req && !reg_we;

  // One comparator per legal divisor code
  localparam logic [3:0][15:0] DIV_CODES =
    {`RPC_DIV_115200, `RPC_DIV_38400, `RPC_DIV_19200, `RPC_DIV_9600};
  logic [3:0] code_hit;

  for (genvar gi = 0; gi < 4; gi++) begin : g_code
    assign code_hit[gi] = (reg_wdata == DIV_CODES[gi]);
  end

  assign baud_ok = |code_hit;

  always_comb begin
    baud_set_nxt = baud_set_r;
    baud_sav_nxt = baud_sav_r;
    stn_set_nxt = stn_set_r;
    stn_sav_nxt = stn_sav_r;
    proto_set_nxt = proto_set_r;
    proto_sav_nxt = proto_sav_r;
    baud_nxt = baud_r;
    stn_nxt = stn_r;
    proto_nxt = proto_r;
    casc_nxt = casc_r;
    ack_nxt = reg_req;
    err_nxt = 1'b0;
    boot_nxt = 1'b0;
    rst_nxt = 1'b0;
    rdata_nxt = 16'h0000;
    if (rd) begin
      case (reg_addr)
        `RPC_ADDR_BAUD: rdata_nxt = baud_set_r;
        `RPC_ADDR_STATION: rdata_nxt = stn_set_r;
        `RPC_ADDR_PROTO: rdata_nxt = {14'h0000, proto_set_r};
        `RPC_ADDR_CASCADE: rdata_nxt = {15'h0000, casc_r};
        `RPC_ADDR_FORMAT: rdata_nxt = `RPC_FORMAT_WORD;
        `RPC_ADDR_RESTART: rdata_nxt = 16'h0000;
        `RPC_ADDR_STORE: rdata_nxt = 16'h0000;
        default: err_nxt = 1'b1;
      endcase
    end else if (wr) begin
      case (reg_addr)
        `RPC_ADDR_BAUD: begin
          // Unknown codes refused so the divider never sees a bad value
          if (baud_ok) begin
            baud_set_nxt = reg_wdata;
          end else begin
            err_nxt = 1'b1;
          end
        end
        `RPC_ADDR_STATION: stn_set_nxt = reg_wdata;
        `RPC_ADDR_PROTO: begin
          proto_set_nxt = reg_wdata[1:0];
          if (!reg_wdata[`RPC_PROTO_DEFER_BIT]) begin
            proto_nxt = reg_wdata[`RPC_PROTO_SEL_BIT];
          end
        end
        `RPC_ADDR_CASCADE: casc_nxt = reg_wdata[0];
        `RPC_ADDR_STORE: begin
          if (reg_wdata == `RPC_CMD_STORE) begin
            baud_sav_nxt = baud_set_r;
            stn_sav_nxt = stn_set_r;
            proto_sav_nxt = proto_set_r;
          end else begin
            err_nxt = 1'b1;
          end
        end
        `RPC_ADDR_RESTART: begin
          if (reg_wdata == `RPC_CMD_BOOT) begin
            boot_nxt = 1'b1;
          end else if (reg_wdata == `RPC_CMD_RESTART) begin
            // Restart drops unsaved baud, station and protocol settings, as the real drive would
            rst_nxt = 1'b1;
            baud_nxt = baud_sav_r;
            stn_nxt = stn_sav_r;
            proto_nxt = proto_sav_r[`RPC_PROTO_SEL_BIT];
            baud_set_nxt = baud_sav_r;
            stn_set_nxt = stn_sav_r;
            proto_set_nxt = proto_sav_r;
          end else begin
            err_nxt = 1'b1;
          end
        end
        default: err_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      baud_set_r <= BAUD_RST;
      baud_sav_r <= BAUD_RST;
      baud_r <= BAUD_RST;
      stn_set_r <= `RPC_STATION_RST;
      stn_sav_r <= `RPC_STATION_RST;
      stn_r <= `RPC_STATION_RST;
      proto_set_r <= PROTO_RST[1:0];
      proto_sav_r <= PROTO_RST[1:0];
      proto_r <= PROTO_RST[0];
      casc_r <= 1'(`RPC_CASCADE_RST);
      ack_r <= 1'b0;
      err_r <= 1'b0;
      boot_r <= 1'b0;
      rst_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else if (ce) begin
      baud_set_r <= baud_set_nxt;
      baud_sav_r <= baud_sav_nxt;
      baud_r <= baud_nxt;
      stn_set_r <= stn_set_nxt;
      stn_sav_r <= stn_sav_nxt;
      stn_r <= stn_nxt;
      proto_set_r <= proto_set_nxt;
      proto_sav_r <= proto_sav_nxt;
      proto_r <= proto_nxt;
      casc_r <= casc_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      boot_r <= boot_nxt;
      rst_r <= rst_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Fractional accumulator gives a 10.368 MHz reference without a second clock
  always_comb begin
    acc_nxt = acc_r + `RPC_REF_KHZ;
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (acc_nxt >= `RPC_MCLK_KHZ) begin
      acc_nxt = acc_nxt - `RPC_MCLK_KHZ;
      if (cnt_r >= baud_r - 16'h0001) begin
        cnt_nxt = 16'h0000;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
    if (rst_nxt) begin
      cnt_nxt = 16'h0000;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= 18'h0_0000;
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (ce) begin
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign reg_ack = ack_r;
  assign reg_err = err_r;
  assign reg_rdata = rdata_r;
  assign baud_div = baud_r;
  assign station_id = stn_r;
  assign proto_host = proto_r;
  assign cascade_mode = casc_r;
  assign data_bits = `RPC_DATA_BITS;
  assign stop_bits = `RPC_STOP_BITS;
  assign parity_en = `RPC_PARITY_EN;
  assign bit_tick = tick_r;
  assign boot_req = boot_r;
  assign restart_req = rst_r;

  chk_baud_legal: assert property (@(posedge mclk) disable iff (!nrst)
    (baud_div == `RPC_DIV_9600) || (baud_div == `RPC_DIV_19200) ||
    (baud_div == `RPC_DIV_38400) || (baud_div == `RPC_DIV_115200))
    else $error("active baud divisor is not a legal code");

  chk_active_defer: assert property (@(posedge mclk) disable iff (!nrst)
    ($changed(baud_div) || $changed(station_id)) |-> restart_req)
    else $error("baud or station changed without restart");

  chk_proto_now: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wr && reg_addr == `RPC_ADDR_PROTO && !reg_wdata[1])
      |=> (proto_host == $past(reg_wdata[0])))
    else $error("immediate protocol write not applied");

  chk_proto_later: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wr && reg_addr == `RPC_ADDR_PROTO && reg_wdata[1]) |=> $stable(proto_host))
    else $error("deferred protocol write applied at once");

  chk_frame_fixed: assert property (@(posedge mclk) disable iff (!nrst)
    (data_bits == 4'h8) && (stop_bits == 2'h1) && !parity_en)
    else $error("frame format is not 8N1");

  chk_cascade_sel: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wr && reg_addr == `RPC_ADDR_CASCADE) |=> (cascade_mode == $past(reg_wdata[0])))
    else $error("cascade mode not taken from write");

  chk_boot_cmd: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wr && reg_addr == `RPC_ADDR_RESTART && reg_wdata == 16'h55aa)
      |=> (boot_req && !restart_req && !reg_err))
    else $error("bootloader command not raised");

  chk_restart_cmd: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wr && reg_addr == `RPC_ADDR_RESTART && reg_wdata == 16'haa55)
      |=> (restart_req && proto_host == $past(proto_sav_r[0])))
    else $error("restart command not applied");

  chk_store_copy: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wr && reg_addr == `RPC_ADDR_STORE && reg_wdata == 16'h0001)
      |=> (baud_sav_r == $past(baud_set_r) && stn_sav_r == $past(stn_set_r)))
    else $error("store did not save pending settings");

  chk_ref_range: assert property (@(posedge mclk) disable iff (!nrst)
    (acc_r < 18'h3_0d40) && (cnt_r < baud_r))
    else $error("bit timing counters out of range");

  chk_baud_refused: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wr && reg_addr == `RPC_ADDR_BAUD && !baud_ok)
      |=> (reg_err && baud_set_r == $past(baud_set_r)))
    else $error("illegal divisor code was not refused");

  chk_write_pending: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wr && (reg_addr == `RPC_ADDR_BAUD || reg_addr == `RPC_ADDR_STATION))
      |=> ($stable(baud_div) && $stable(station_id)))
    else $error("pending write reached the active settings");

  chk_read_still: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && rd) |=> ($stable(baud_div) && $stable(station_id) &&
      $stable(proto_host) && $stable(cascade_mode)))
    else $error("read access changed the active settings");

  chk_format_read: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && rd && reg_addr == `RPC_ADDR_FORMAT)
      |=> (reg_rdata == 16'h0081 && !reg_err))
    else $error("frame format read back wrong");

  chk_tick_single: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && bit_tick) |=> !bit_tick)
    else $error("bit tick wider than one cycle");

endmodule

`default_nettype wire

// ==== tb/rpc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rpc_cfg.svh"

module rpc_host_model (
  // Clock
  input wire logic mclk,
  // Parameter access port
  output logic reg_req,
  output logic reg_we,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_req = 1'b0;
    reg_we = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end

  // Call at a rising edge; one-cycle request so a write is never taken twice
  task automatic access(input logic we, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rd, output logic er);
    int n;
    n = 0;
    reg_req <= 1'b1;
    reg_we <= we;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_req <= 1'b0;
    // Released lines flip so a stale value cannot pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
    do begin
      @(posedge mclk);
      n++;
    end while (reg_ack !== 1'b1 && n < 4);
    rd = reg_rdata;
    // Missing answer shows as unknown so the caller's compare trips
    er = (reg_ack === 1'b1) ? reg_err : 1'bx;
  endtask

  task automatic save_restart(output logic er);
    logic [15:0] rd;
    access(1'b1, `RPC_ADDR_STORE, `RPC_CMD_STORE, rd, er);
    access(1'b1, `RPC_ADDR_RESTART, `RPC_CMD_RESTART, rd, er);
  endtask
endmodule

`default_nettype wire

// ==== tb/rpc_port_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rpc_cfg.svh"

module rpc_port_config_tb
  import rpc_pkg::*;
;
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic err;
  } rpc_row_type;

  logic mclk, nrst, ce, reg_req, reg_we, reg_ack, reg_err;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, baud_div, station_id, b_baud;
  logic proto_host, cascade_mode, parity_en, bit_tick, boot_req, restart_req, b_proto;
  logic [3:0] data_bits;
  logic [1:0] stop_bits;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  rpc_row_type rows [12];

  rpc_port_config #(.VARIANT(RPC_VARIANT_A)) dut (.mclk(mclk), .nrst(nrst), .ce(ce),
    .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .reg_rdata(reg_rdata), .baud_div(baud_div),
    .station_id(station_id), .proto_host(proto_host), .cascade_mode(cascade_mode),
    .data_bits(data_bits), .stop_bits(stop_bits), .parity_en(parity_en),
    .bit_tick(bit_tick), .boot_req(boot_req), .restart_req(restart_req));

  rpc_port_config #(.VARIANT(RPC_VARIANT_B)) dut_b (.mclk(mclk), .nrst(nrst), .ce(ce),
    .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_ack(), .reg_err(), .reg_rdata(), .baud_div(b_baud), .station_id(),
    .proto_host(b_proto), .cascade_mode(), .data_bits(), .stop_bits(), .parity_en(),
    .bit_tick(), .boot_req(), .restart_req());

  rpc_host_model host (.mclk(mclk), .reg_req(reg_req), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_err(reg_err),
    .reg_rdata(reg_rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Whole run is about 3500 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    logic [15:0] rd;
    logic er;
    int gap;
    nrst = 1'b0;
    ce = 1'b1;
    rows = '{
      '{1'b1, `RPC_ADDR_BAUD, `RPC_DIV_9600, 16'h0000, 1'b0},
      '{1'b0, `RPC_ADDR_BAUD, 16'h0000, `RPC_DIV_9600, 1'b0},
      '{1'b1, `RPC_ADDR_BAUD, `RPC_DIV_19200, 16'h0000, 1'b0},
      '{1'b1, `RPC_ADDR_BAUD, `RPC_DIV_115200, 16'h0000, 1'b0},
      '{1'b1, `RPC_ADDR_BAUD, 16'h0437, 16'h0000, 1'b1},
      '{1'b0, `RPC_ADDR_BAUD, 16'h0000, `RPC_DIV_115200, 1'b0},
      '{1'b0, `RPC_ADDR_FORMAT, 16'h0000, `RPC_FORMAT_WORD, 1'b0},
      '{1'b1, `RPC_ADDR_FORMAT, 16'h0000, 16'h0000, 1'b1},
      '{1'b0, 16'h1234, 16'h0000, 16'h0000, 1'b1},
      '{1'b1, `RPC_ADDR_STORE, 16'h0002, 16'h0000, 1'b1},
      '{1'b1, `RPC_ADDR_RESTART, 16'h1234, 16'h0000, 1'b1},
      '{1'b1, `RPC_ADDR_CASCADE, 16'h0001, 16'h0000, 1'b0}};
    repeat (5) @(posedge mclk);
    check(baud_div, `RPC_DIV_38400);
    check(16'({proto_host, cascade_mode}), 16'h0000);
    check(b_baud, `RPC_DIV_115200);
    check(16'(b_proto), 16'h0001);
    check(16'({data_bits, stop_bits, parity_en}), 16'h0042);
    nrst <= 1'b1;
    @(posedge mclk);
    $display("reset test done");
    foreach (rows[i]) begin
      host.access(rows[i].we, rows[i].addr, rows[i].wdata, rd, er);
      check(rd, rows[i].rdata);
      check(16'(er), 16'(rows[i].err));
    end
    check(baud_div, `RPC_DIV_38400);
    check(16'(cascade_mode), 16'h0001);
    $display("table test done");
    // Enable low: request must be ignored and state frozen
    ce <= 1'b0;
    host.access(1'b1, `RPC_ADDR_CASCADE, 16'h0000, rd, er);
    check(16'({reg_ack, cascade_mode}), 16'h0001);
    ce <= 1'b1;
    @(posedge mclk);
    $display("enable test done");
    host.access(1'b1, `RPC_ADDR_PROTO, 16'h0001, rd, er);
    check(16'(proto_host), 16'h0001);
    host.access(1'b1, `RPC_ADDR_PROTO, 16'h0000, rd, er);
    check(16'(proto_host), 16'h0000);
    host.access(1'b1, `RPC_ADDR_STATION, 16'h0007, rd, er);
    host.access(1'b1, `RPC_ADDR_PROTO, 16'h0003, rd, er);
    host.access(1'b0, `RPC_ADDR_PROTO, 16'h0000, rd, er);
    check(rd, 16'h0003);
    check(16'(proto_host), 16'h0000);
    check(station_id, `RPC_STATION_RST);
    $display("protocol test done");
    host.save_restart(er);
    check(16'({boot_req, restart_req}), 16'h0001);
    @(posedge mclk);
    check(baud_div, `RPC_DIV_115200);
    check(station_id, 16'h0007);
    check(16'(proto_host), 16'h0001);
    host.access(1'b1, `RPC_ADDR_RESTART, `RPC_CMD_BOOT, rd, er);
    check(16'({boot_req, restart_req}), 16'h0002);
    $display("restart test done");
    gap = 0;
    @(posedge mclk iff bit_tick === 1'b1);
    do begin
      @(posedge mclk);
      gap++;
    end while (bit_tick !== 1'b1 && gap < 4000);
    // Gap alternates between two cycle counts, so compare the halves
    check(16'(gap / 2), 16'(90 * `RPC_MCLK_KHZ / `RPC_REF_KHZ / 2));
    $display("bit timing test done");
    give_verdict();
  end
endmodule

`default_nettype wire
